// file: dv/nfhc_flash_model.sv
/*
  Behavioural four-die NAND flash model standing on the host pins.
  Assumes ready/busy is pulled up and one shared page register serves all dies.
*/
`timescale 1ns/10ps
module nfhc_flash_model
  import nfhc_pkg::*;
#(
  parameter int         T_OUT_NS = 20,
  parameter int         T_RD_NS  = 2000,
  parameter int         T_PG_NS  = 4000,
  parameter int         T_ER_NS  = 8000,
  parameter logic [7:0] STAT_VAL = 8'hc0
)
(
  input  wire nfhc_pins_t      pins_i,
  input  wire logic [7:0]      host_io_i,
  input  wire logic            host_oe_i,
  output logic [7:0]           bus_o,
  output logic [NUM_DIES-1:0]  rb_o
);
  logic [7:0]          mem [longint];
  logic [7:0]          pg [PAGE_BYTES];
  logic [9:0]          log_q [$];
  logic [NUM_DIES-1:0] busy = '0;
  logic [7:0]          dq = 8'h00;
  logic [7:0]          adr [5];
  logic                drv = 1'b0;
  logic                stat = 1'b0;
  int                  acnt, col, die, sel_err = 0, busy_err = 0, rd_err = 0;
  realtime             t_fall = -100.0;

  assign rb_o  = ~busy;
  assign bus_o = host_oe_i ? host_io_i : (drv ? dq : ~dq);

  function automatic int pick();
    int n = 0;
    pick = -1;
    for (int i = 0; i < NUM_DIES; i++)
      if (!pins_i.die_select_n[i])
      begin
        n++;
        pick = i;
      end
    if (n > 1)
      sel_err++;
  endfunction

  function automatic longint key(int d, logic [ROW_W-1:0] r, int c);
    return (longint'(d) << 32) | (longint'(r) << 12) | longint'(c);
  endfunction

  // Busy runs on regardless of the die select
  task automatic go_busy(int d, int ns);
    busy[d] = 1'b1;
    fork
      begin
        #(ns);
        busy[d] = 1'b0;
      end
    join_none
  endtask

  task automatic take(logic [7:0] b);
    logic [ROW_W-1:0] row;
    row = {adr[4][2:0], adr[3], adr[2]};
    if (pins_i.cmd_latch)
    begin
      log_q.push_back({2'h0, b});
      if (busy[die] && b != CMD_RESET && b != CMD_STATUS)
        busy_err++;
      else
      begin
        stat = (b == CMD_STATUS);
        acnt = (b == CMD_ERASE_SETUP) ? 2 : 0;
        if (b == CMD_PROG_SETUP)
          pg = '{default: 8'hff};
        if (b == CMD_READ_GO)
        begin
          foreach (pg[c])
            pg[c] = mem.exists(key(die, row, c)) ? mem[key(die, row, c)] : 8'hff;
          go_busy(die, T_RD_NS);
        end
        if (b == CMD_PROG_GO && pins_i.prog_lock_n)
        begin
          foreach (pg[c])
            mem[key(die, row, c)] = pg[c];
          go_busy(die, T_PG_NS);
        end
        if (b == CMD_ERASE_GO && pins_i.prog_lock_n)
        begin
          for (int p = 0; p < 64; p++)
            foreach (pg[c])
              mem.delete(key(die, {row[ROW_W-1:6], 6'(p)}, c));
          go_busy(die, T_ER_NS);
        end
        if (b == CMD_RESET)
          go_busy(die, 400);
      end
    end
    else if (pins_i.addr_latch)
    begin
      log_q.push_back({2'h1, b});
      if (acnt < 5)
        adr[acnt] = b;
      acnt++;
      col = {adr[1][3:0], adr[0]};
    end
    else
    begin
      log_q.push_back({2'h2, b});
      if (col < PAGE_BYTES)
        pg[col] = b;
      col++;
    end
  endtask

  always @(posedge pins_i.in_strobe_n)
  begin
    die = pick();
    if (die >= 0)
      take(host_io_i);
  end

  always @(negedge pins_i.output_strobe_n)
  begin
    die = pick();
    if (die >= 0)
    begin
      if ((busy[die] && !stat) || $realtime - t_fall < 50.0)
        rd_err++;
      t_fall = $realtime;
      dq = stat ? STAT_VAL : pg[col];
      if (!stat)
        col++;
      #(T_OUT_NS);
      drv = !pins_i.output_strobe_n;
    end
  end

  always @(posedge pins_i.output_strobe_n)
    drv = 1'b0;
endmodule

// file: dv/nfhc_host_bench.sv
/*
  Self-checking bench for the NAND flash host controller.
  Assumes the flash model stands on the pins and pulls ready/busy up.
*/
`timescale 1ns/10ps
module nfhc_host_bench
  import nfhc_pkg::*;
;
  localparam logic [ROW_W-1:0] R1 = 19'h41234;
  logic       ref_clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, req_valid_i = 1'b0;
  nfhc_req_t  req_i = '0;
  logic       wp_n_i = 1'b1, wdata_valid_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic       wdata_ready_o, rdata_valid_o, req_ready_o, done_o, io_oe_o;
  logic [7:0] rdata_o, io_o, io_i;
  logic [3:0] rb;
  nfhc_pins_t pins_o;
  logic [7:0] wr_q [$], rd_q [$];
  logic [9:0] exp_q [$];
  int         error_cnt = 0, checks = 0;

  always #4 ref_clk_i = ~ref_clk_i;

  nfhc_host dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .wp_n_i(wp_n_i), .wdata_i(wdata_i), .wdata_valid_i(wdata_valid_i),
    .wdata_ready_o(wdata_ready_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
    .req_ready_o(req_ready_o), .done_o(done_o), .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o),
    .ready_busy_i(rb), .pins_o(pins_o));
  nfhc_flash_model model_u (.pins_i(pins_o), .host_io_i(io_o), .host_oe_i(io_oe_o), .bus_o(io_i), .rb_o(rb));

  task automatic test_done;
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp_val(logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_log;
    cmp_val(model_u.log_q.size(), exp_q.size());
    foreach (exp_q[i])
      cmp_val(model_u.log_q[i], exp_q[i]);
    model_u.log_q.delete();
    exp_q.delete();
  endtask

  task automatic ex(logic [1:0] k, logic [7:0] b);
    exp_q.push_back({k, b});
  endtask

  task automatic ex_row(logic [ROW_W-1:0] r);
    ex(2'h1, r[7:0]);
    ex(2'h1, r[15:8]);
    ex(2'h1, {5'h00, r[18:16]});
  endtask

  task automatic run_op(nfhc_op_t op, logic [1:0] d, logic [COL_W-1:0] c, logic [ROW_W-1:0] r, logic [COL_W:0] n);
    int k = 0;
    int wi = 0;
    rd_q.delete();
    wait (rb[d] === 1'b1);
    repeat (4) @(posedge ref_clk_i);
    req_i <= '{op, d, c, r, n};
    req_valid_i <= 1'b1;
    wdata_i <= (wr_q.size() > 0) ? wr_q[0] : 8'h00;
    wdata_valid_i <= (op == OP_PROG);
    @(posedge ref_clk_i);
    req_valid_i <= 1'b0;
    while (done_o !== 1'b1 && k < 20000)
    begin
      @(posedge ref_clk_i);
      k++;
      if (rdata_valid_o === 1'b1)
        rd_q.push_back(rdata_o);
      if (wdata_valid_i && wdata_ready_o === 1'b1)
        wi++;
      wdata_valid_i <= (op == OP_PROG) && (wi < n);
      wdata_i <= (wi < wr_q.size()) ? wr_q[wi] : 8'h00;
    end
    cmp_val(k < 20000, 1'b1);
  endtask

  task automatic t_reset;
    repeat (12) @(posedge ref_clk_i);
    cmp_val({pins_o.cmd_latch, pins_o.addr_latch, pins_o.in_strobe_n, pins_o.output_strobe_n,
      pins_o.prog_lock_n, io_oe_o}, 6'h0c);
    cmp_val(pins_o.die_select_n, 4'hf);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    cmp_val(pins_o.prog_lock_n, 1'b1);
  endtask

  task automatic t_misc;
    run_op(OP_STATUS, 2'd0, '0, '0, 13'd1);
    cmp_val(rd_q.size(), 1);
    cmp_val(rd_q[0], 8'hc0);
    ex(2'h0, CMD_STATUS);
    cmp_log;
    run_op(OP_RESET, 2'd3, '0, '0, 13'd1);
    ex(2'h0, CMD_RESET);
    cmp_log;
  endtask

  task automatic t_prog;
    wr_q = '{8'ha5, 8'h5a, 8'h3c, 8'hc3};
    run_op(OP_PROG, 2'd1, 12'h003, R1, 13'd4);
    ex(2'h0, CMD_PROG_SETUP);
    ex(2'h1, 8'h03);
    ex(2'h1, 8'h00);
    ex_row(R1);
    foreach (wr_q[i])
      ex(2'h2, wr_q[i]);
    ex(2'h0, CMD_PROG_GO);
    cmp_log;
  endtask

  task automatic t_read(logic erased);
    logic [7:0] e [6];
    if (erased)
      e = '{6{8'hff}};
    else
      e = '{8'hff, 8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'hff};
    run_op(OP_READ, 2'd1, 12'h002, R1, 13'd6);
    cmp_val(rd_q.size(), 6);
    foreach (e[i])
      cmp_val(rd_q[i], e[i]);
    ex(2'h0, CMD_READ_SETUP);
    ex(2'h1, 8'h02);
    ex(2'h1, 8'h00);
    ex_row(R1);
    ex(2'h0, CMD_READ_GO);
    cmp_log;
  endtask

  task automatic t_erase;
    run_op(OP_ERASE, 2'd1, '0, R1 ^ 19'h1, 13'd0);
    ex(2'h0, CMD_ERASE_SETUP);
    ex_row(R1 ^ 19'h1);
    ex(2'h0, CMD_ERASE_GO);
    cmp_log;
    t_read(1'b1);
  endtask

  task automatic t_lock;
    wp_n_i <= 1'b0;
    run_op(OP_PROG, 2'd2, '0, 19'h00100, 13'd4);
    cmp_val(pins_o.prog_lock_n, 1'b0);
    wp_n_i <= 1'b1;
    run_op(OP_READ, 2'd2, '0, 19'h00100, 13'd2);
    cmp_val({rd_q[0], rd_q[1]}, 16'hffff);
    model_u.log_q.delete();
  endtask

  initial
  begin
    t_reset;
    t_misc;
    t_prog;
    t_read(1'b0);
    t_erase;
    t_lock;
    cmp_val(model_u.busy_err, 0);
    cmp_val(model_u.sel_err, 0);
    cmp_val(model_u.rd_err, 0);
    test_done;
  end

  initial
  begin
    #200000;
    error_cnt++;
    test_done;
  end
endmodule

// file: inc/nfhc_pkg.sv
/*
  Package for the NAND flash host controller: command codes, cycle counts,
  pin and request carriers, and the sequencer states.
  Assumes a 125 MHz controller clock.
*/
package nfhc_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned T_STROBE_NS     = 25;
  localparam int unsigned T_STROBE_DSP_NS = 50;
  localparam int unsigned STROBE_CYC      = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_DSP_CYC  = (T_STROBE_DSP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PHASE_CYC       = (STROBE_DSP_CYC + 1) / 2;
  localparam int unsigned T_BUSY_SEEN_NS  = 200;
  localparam int unsigned BUSY_SEEN_CYC   = T_BUSY_SEEN_NS / CLK_PERIOD_NS;

  localparam int unsigned PAGE_BYTES      = 2048 + 64;
  localparam int unsigned COL_W           = 12;
  localparam int unsigned ROW_W           = 19;
  localparam int unsigned NUM_DIES        = 4;

  localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
  localparam logic [7:0] CMD_READ_GO      = 8'h30;
  localparam logic [7:0] CMD_PROG_SETUP   = 8'h80;
  localparam logic [7:0] CMD_PROG_GO      = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO     = 8'hd0;
  localparam logic [7:0] CMD_STATUS       = 8'h70;
  localparam logic [7:0] CMD_RESET        = 8'hff;

  localparam logic [2:0] COL_CYCLES       = 3'h2;
  localparam logic [2:0] ADDR_CYCLES      = 3'h5;
  localparam logic [2:0] ROW_FIRST        = 3'h2;

  typedef enum logic [2:0] {
    OP_READ, OP_PROG, OP_ERASE, OP_STATUS, OP_RESET
  } nfhc_op_t;

  typedef struct packed {
    nfhc_op_t             op;
    logic [1:0]           die;
    logic [COL_W-1:0]     col;
    logic [ROW_W-1:0]     row;
    logic [COL_W:0]       len;
  } nfhc_req_t;

  typedef struct packed {
    logic                 cmd_latch;
    logic                 addr_latch;
    logic                 in_strobe_n;
    logic                 output_strobe_n;
    logic                 prog_lock_n;
    logic [NUM_DIES-1:0]  die_select_n;
  } nfhc_pins_t;

  typedef enum {
    S_IDLE, S_CMD1, S_ADDR, S_DIN, S_CMD2, S_WAIT, S_DOUT, S_DONE
  } nfhc_state_t;

endpackage

// file: rtl/nfhc_host.sv
/*
  NAND flash host controller: runs read, program, erase, status and reset
  sequences on the multiplexed byte bus of a stacked NAND part.
  Assumes the flash pins are tied to the pin outputs and ready/busy
  is pulled up externally; write data arrives from logic on the same clock.
*/
`timescale 1ns/10ps
// Function
// - Command bytes strobed with command latch select high
// - Address bytes strobed with address latch select high
// - All bytes share eight lines; device samples on strobe rise
// - Only the addressed die select is asserted
// - Five address cycles: two column then three row
// - Read 00h addr 30h; program 80h addr data 10h
// - Erase 60h, three row cycles, D0h
module nfhc_host
  import nfhc_pkg::*;
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 ce_i,
  input  wire logic                 req_valid_i,
  input  wire nfhc_req_t            req_i,
  input  wire logic                 wp_n_i,
  input  wire logic [7:0]           wdata_i,
  input  wire logic                 wdata_valid_i,
  output logic                      wdata_ready_o,
  output logic [7:0]                rdata_o,
  output logic                      rdata_valid_o,
  output logic                      req_ready_o,
  output logic                      done_o,
  input  wire logic [7:0]           io_i,
  output logic [7:0]                io_o,
  output logic                      io_oe_o,
  input  wire logic [NUM_DIES-1:0]  ready_busy_i,
  output nfhc_pins_t                pins_o
);

  nfhc_state_t      st_r,  st_nxt;
  nfhc_req_t        rq_r,  rq_nxt;
  logic [2:0]       ac_r,  ac_nxt;
  logic [COL_W:0]   bc_r,  bc_nxt;
  logic [7:0]       bus_r, bus_nxt;
  logic             cl_r,  cl_nxt;
  logic             al_r,  al_nxt;
  logic             oe_r,  oe_nxt;
  logic             wr_r,  wr_nxt;
  logic             go_r,  go_nxt;
  logic [7:0]       bw_r,  bw_nxt;
  logic [NUM_DIES-1:0] rb_m_r, rb_s_r;
  logic [7:0]       io_m_r, io_s_r;
  logic [7:0]       rd_r, rd_nxt;
  logic             rv_r, rv_nxt, dn_r, dn_nxt, wrdy_r, wrdy_nxt;
  logic             s_low, s_rise, s_busy;
  logic [1:0]       rs_r,  rs_nxt;
  logic             rr_r,  rr_nxt;

  function automatic logic [7:0] addr_byte(input nfhc_req_t r, input logic [2:0] i);
    logic [39:0] a;
    // Column high byte and last row byte carry zeros above their bits
    a = {5'h00, r.row, 4'h0, r.col};
    return a[8*i +: 8];
  endfunction

  function automatic logic [NUM_DIES-1:0] die_onehot(input logic [1:0] d);
    return NUM_DIES'(1) << d;
  endfunction

  // Pin inputs pass two flops before use
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rb_m_r <= '1;
      rb_s_r <= '1;
      io_m_r <= 8'h00;
      io_s_r <= 8'h00;
    end
    else if (ce_i)
    begin
      rb_m_r <= ready_busy_i;
      rb_s_r <= rb_m_r;
      io_m_r <= io_i;
      io_s_r <= io_m_r;
    end
  end

  logic die_ready;
  assign die_ready = rb_s_r[rq_r.die];

  nfhc_strobe u_strobe (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .go_i      (go_r),
    .low_o     (s_low),
    .rise_o    (s_rise),
    .fall_o    (),
    .busy_o    (s_busy)
  );

  always_comb
  begin
    st_nxt = st_r; rq_nxt = rq_r; ac_nxt = ac_r; bc_nxt = bc_r;
    bus_nxt = bus_r; cl_nxt = cl_r; al_nxt = al_r; oe_nxt = oe_r;
    wr_nxt = wr_r; go_nxt = 1'b0; bw_nxt = bw_r;
    rd_nxt = rd_r; rv_nxt = 1'b0; dn_nxt = 1'b0; wrdy_nxt = 1'b0;
    rs_nxt = {rs_r[0], s_rise};
    unique case (st_r)
      S_IDLE:
      begin
        cl_nxt = 1'b0; al_nxt = 1'b0; oe_nxt = 1'b0;
        if (req_valid_i)
        begin
          rq_nxt = req_i;
          // Read, program, erase wait for ready; status and reset do not
          if (req_i.op == OP_STATUS || req_i.op == OP_RESET || rb_s_r[req_i.die])
          begin
            st_nxt = S_CMD1;
            unique case (req_i.op)
              OP_READ:   bus_nxt = CMD_READ_SETUP;
              OP_PROG:   bus_nxt = CMD_PROG_SETUP;
              OP_ERASE:  bus_nxt = CMD_ERASE_SETUP;
              OP_STATUS: bus_nxt = CMD_STATUS;
              default:   bus_nxt = CMD_RESET;
            endcase
            cl_nxt = 1'b1; oe_nxt = 1'b1; wr_nxt = 1'b1; go_nxt = 1'b1;
            ac_nxt = (req_i.op == OP_ERASE) ? ROW_FIRST : 3'h0;
            bc_nxt = req_i.len;
          end
        end
      end
      S_CMD1, S_ADDR, S_DIN, S_CMD2:
      begin
        if (!s_busy && !go_r)
        begin
          cl_nxt = 1'b0; al_nxt = 1'b0;
          if (st_r == S_CMD1 && (rq_r.op == OP_STATUS))
          begin
            oe_nxt = 1'b0; bc_nxt = (COL_W+1)'(1); st_nxt = S_DOUT; go_nxt = 1'b1; wr_nxt = 1'b0;
          end
          else if (st_r == S_CMD1 && rq_r.op == OP_RESET)
            st_nxt = S_WAIT;
          else if ((st_r == S_CMD1 || st_r == S_ADDR) && ac_r != ADDR_CYCLES)
          begin
            st_nxt = S_ADDR; al_nxt = 1'b1; go_nxt = 1'b1;
            bus_nxt = addr_byte(rq_r, ac_r); ac_nxt = ac_r + 3'h1;
          end
          else if (st_r != S_CMD2 && rq_r.op == OP_PROG && bc_r != '0)
          begin
            st_nxt = S_DIN; wrdy_nxt = 1'b1;
            if (wdata_valid_i && wrdy_r)
            begin
              wrdy_nxt = 1'b0; bus_nxt = wdata_i; go_nxt = 1'b1; bc_nxt = bc_r - 1'b1;
            end
          end
          else if (st_r != S_CMD2)
          begin
            st_nxt = S_CMD2; cl_nxt = 1'b1; go_nxt = 1'b1;
            bus_nxt = (rq_r.op == OP_READ) ? CMD_READ_GO :
                      (rq_r.op == OP_PROG) ? CMD_PROG_GO : CMD_ERASE_GO;
          end
          else
          begin
            st_nxt = S_WAIT; oe_nxt = 1'b0; bw_nxt = 8'(BUSY_SEEN_CYC);
          end
        end
      end
      S_WAIT:
      begin
        // Read, program and erase must see ready after the busy onset window; reset enters with no window
        oe_nxt = 1'b0;
        if (bw_r != 8'h00)
          bw_nxt = bw_r - 8'h01;
        else if (die_ready)
        begin
          if (rq_r.op == OP_READ && bc_r != '0)
          begin
            st_nxt = S_DOUT; go_nxt = 1'b1; wr_nxt = 1'b0;
          end
          else
            st_nxt = S_DONE;
        end
      end
      S_DOUT:
      begin
        // Sample two cycles after the last low cycle, while the byte is still driven
        if (rs_r[1])
          rd_nxt = io_s_r;
        if (!s_busy && !go_r)
        begin
          rv_nxt = 1'b1; bc_nxt = bc_r - 1'b1;
          if (bc_r == (COL_W+1)'(1))
            st_nxt = S_DONE;
          else
            go_nxt = 1'b1;
        end
      end
      default:
      begin
        dn_nxt = 1'b1; st_nxt = S_IDLE;
      end
    endcase
    rr_nxt = (st_nxt == S_IDLE);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= S_IDLE; rq_r <= '0; ac_r <= 3'h0; bc_r <= '0; bus_r <= 8'h00;
      cl_r <= 1'b0; al_r <= 1'b0; oe_r <= 1'b0; wr_r <= 1'b0; go_r <= 1'b0;
      bw_r <= 8'h00; rd_r <= 8'h00; rv_r <= 1'b0; dn_r <= 1'b0; wrdy_r <= 1'b0;
      rs_r <= 2'h0; rr_r <= 1'b1;
    end
    else if (ce_i)
    begin
      st_r <= st_nxt; rq_r <= rq_nxt; ac_r <= ac_nxt; bc_r <= bc_nxt; bus_r <= bus_nxt;
      cl_r <= cl_nxt; al_r <= al_nxt; oe_r <= oe_nxt; wr_r <= wr_nxt; go_r <= go_nxt;
      bw_r <= bw_nxt; rd_r <= rd_nxt; rv_r <= rv_nxt; dn_r <= dn_nxt; wrdy_r <= wrdy_nxt;
      rs_r <= rs_nxt; rr_r <= rr_nxt;
    end
  end

  // Registered pin drive
  nfhc_pins_t pins_r;
  logic [7:0] io_r;
  logic       io_oe_r;
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pins_r  <= '{cmd_latch: 1'b0, addr_latch: 1'b0, in_strobe_n: 1'b1, output_strobe_n: 1'b1,
                   prog_lock_n: 1'b0, die_select_n: '1};
      io_r    <= 8'h00;
      io_oe_r <= 1'b0;
    end
    else if (ce_i)
    begin
      pins_r.cmd_latch       <= cl_r;
      pins_r.addr_latch      <= al_r;
      pins_r.in_strobe_n     <= !(s_low && wr_r);
      pins_r.output_strobe_n <= !(s_low && !wr_r);
      pins_r.prog_lock_n     <= wp_n_i;
      pins_r.die_select_n    <= (st_r == S_IDLE) ? '1 : ~die_onehot(rq_r.die);
      io_r                   <= bus_r;
      io_oe_r                <= oe_r && wr_r;
    end
  end

  assign pins_o        = pins_r;
  assign io_o          = io_r;
  assign io_oe_o       = io_oe_r;
  assign rdata_o       = rd_r;
  assign rdata_valid_o = rv_r;
  assign done_o        = dn_r;
  assign req_ready_o   = rr_r;
  assign wdata_ready_o = wrdy_r;

  property p_sel_onehot;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (pins_r.die_select_n != '1) |-> $onehot(~pins_r.die_select_n);
  endproperty
  a_sel_onehot: assert property (p_sel_onehot) else $error("More than one die selected");

  property p_no_both_strobes;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      !(!pins_r.in_strobe_n && !pins_r.output_strobe_n);
  endproperty
  a_no_both_strobes: assert property (p_no_both_strobes) else $error("Both strobes low");

  property p_no_drive_on_read;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      !pins_r.output_strobe_n |-> !io_oe_r;
  endproperty
  a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("Bus driven during read");

  property p_latch_excl;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      !(pins_r.cmd_latch && pins_r.addr_latch);
  endproperty
  a_latch_excl: assert property (p_latch_excl) else $error("Both latch selects high");

  sequence s_strobe_low;
    $fell(pins_r.output_strobe_n);
  endsequence
  property p_read_cycle;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_strobe_low |-> !pins_r.output_strobe_n [*2];
  endproperty
  a_read_cycle: assert property (p_read_cycle) else $error("Read strobe low too short");

  property p_wait_ready;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_r == S_WAIT && st_nxt != S_WAIT && ce_i) |-> die_ready;
  endproperty
  a_wait_ready: assert property (p_wait_ready) else $error("Left wait while busy");

  property p_lock_follow;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i |=> (pins_r.prog_lock_n == $past(wp_n_i));
  endproperty
  a_lock_follow: assert property (p_lock_follow) else $error("Lock pin not following");

  property p_addr_count;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_r == S_ADDR) |-> (ac_r <= ADDR_CYCLES);
  endproperty
  a_addr_count: assert property (p_addr_count) else $error("Too many address cycles");

endmodule

// file: rtl/nfhc_strobe.sv
/*
  One strobe cycle generator: low phase then high phase of equal length.
  Assumes go is only raised while idle.
*/
`timescale 1ns/10ps
module nfhc_strobe
  import nfhc_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        go_i,
  output logic             low_o,
  output logic             rise_o,
  output logic             fall_o,
  output logic             busy_o
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       act_r;
  logic       act_nxt;

  localparam logic [3:0] HALF = 4'(PHASE_CYC);
  localparam logic [3:0] FULL = 4'(2 * PHASE_CYC);

  always_comb
  begin
    cnt_nxt = cnt_r;
    act_nxt = act_r;
    if (go_i && !act_r)
    begin
      act_nxt = 1'b1;
      cnt_nxt = 4'h0;
    end
    else if (act_r)
    begin
      cnt_nxt = cnt_r + 4'h1;
      if (cnt_r == FULL - 4'h1)
        act_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r <= 4'h0;
      act_r <= 1'b0;
    end
    else if (ce_i)
    begin
      cnt_r <= cnt_nxt;
      act_r <= act_nxt;
    end
  end

  assign busy_o = act_r;
  assign low_o  = act_r && (cnt_r < HALF);
  assign fall_o = go_i && !act_r;
  assign rise_o = act_r && (cnt_r == HALF - 4'h1);

endmodule
